// *** npc_pkg.sv ***
/*
 * Constants for the program-memory and erasable-memory control block:
 * register offsets, field positions, reset values, address windows and
 * the post-reset write window. Assumes a byte-wide register port with a
 * 6-bit offset into the 64-byte register block.
 */
package npc_pkg;

    // Register offsets inside the register block.
    localparam logic [5:0] OFF_BLOCK_PROTECT  = 6'h35;
    localparam logic [5:0] OFF_ONETIME_CTRL   = 6'h36;
    localparam logic [5:0] OFF_ERASABLE_CTRL  = 6'h3B;
    localparam logic [5:0] OFF_CONFIG         = 6'h3F;

    // One-time array control fields.
    localparam int OT_MBE    = 7;
    localparam int OT_LAT    = 5;
    localparam int OT_EXTRA_COLUMN_SELECT  = 4;
    localparam int OT_EXTRA_ROW_SELECT  = 3;
    localparam int OT_ST_HI  = 2;
    localparam int OT_ST_LO  = 1;
    localparam int OT_PGM    = 0;

    // Erasable array control fields.
    localparam int EE_ODD    = 7;
    localparam int EE_EVEN   = 6;
    localparam int EE_BYTE   = 4;
    localparam int EE_ROW    = 3;
    localparam int EE_ERASE  = 2;
    localparam int EE_LAT    = 1;
    localparam int EE_PGM    = 0;

    // Block protect fields.
    localparam int BP_CFG    = 4;
    localparam int BP_WIDTH  = 5;

    // Configuration fields.
    localparam int CF_NOSEC  = 3;
    localparam int CF_NOCOP  = 2;
    localparam int CF_PROGRAM_ARRAY_MAP_ENABLE  = 1;
    localparam int CF_ERASABLE_ARRAY_MAP_ENABLE   = 0;

    // Reset values.
    localparam logic [7:0] RST_ONETIME_CTRL  = 8'h00;
    localparam logic [7:0] RST_ERASABLE_CTRL = 8'h00;
    localparam logic [4:0] RST_BLOCK_PROTECT = 5'h1F;

    // Address windows of the arrays.
    localparam logic [15:0] ROM_LO_BASE  = 16'h9000;
    localparam logic [15:0] ROM_LO_LAST  = 16'hAFFF;
    localparam logic [15:0] ROM_HI_BASE  = 16'hD000;
    localparam logic [15:0] ROM_HI_LAST  = 16'hFFFF;
    localparam logic [15:0] EE_BASE      = 16'hB600;
    localparam logic [15:0] EE_LAST      = 16'hB7FF;

    // Protect region boundaries as offsets into the erasable array.
    localparam logic [8:0] BP_R1_START = 9'h020;
    localparam logic [8:0] BP_R2_START = 9'h060;
    localparam logic [8:0] BP_R3_START = 9'h0E0;

    // Cycles after reset during which protect bits may be cleared.
    localparam int PROTECT_WINDOW_CYCLES = 64;

    // Operating modes as latched at reset.
    typedef enum logic [1:0] {
        NPC_MODE_BOOT,
        NPC_MODE_TEST,
        NPC_MODE_SINGLE,
        NPC_MODE_EXPANDED
    } npc_mode_e;

    // Erase extent codes driven to the array.
    localparam logic [1:0] ERASE_BULK = 2'h0;
    localparam logic [1:0] ERASE_ROW  = 2'h1;
    localparam logic [1:0] ERASE_BYTE = 2'h2;

endpackage

// *** npc_ctrl.sv ***
/*
 * Program and erase control for the 20 Kbyte one-time program array and
 * the 512-byte erasable array: map decode, latch and voltage sequencing,
 * test access, erase extent and block protection.
 * Assumes mode, configuration cells and the CPU access signals come from
 * logic on clk; only the programming-supply detector comes from a pin.
 */
// The plain strobed port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none

module npc_ctrl #(
    parameter int PROTECT_WINDOW = npc_pkg::PROTECT_WINDOW_CYCLES
) (
    input  wire logic        clk,               // 200 MHz clock.
    input  wire logic        rst_b,             // Asynchronous reset, low.
    input  wire logic [5:0]  reg_addr,          // Register offset.
    input  wire logic [7:0]  reg_wdata,         // Register write data.
    input  wire logic        reg_wr,            // Register write strobe.
    input  wire logic        reg_rd,            // Register read strobe.
    output logic      [7:0]  reg_rdata,         // Read data, next cycle.
    input  wire logic [1:0]  mode_sel,          // Mode latched at reset.
    input  wire logic        special_mode_flag, // Special modes active.
    input  wire logic [3:0]  config_cells,      // Stored configuration.
    input  wire logic        vpp_detect,        // Supply detector pin.
    input  wire logic [15:0] cpu_addr,          // CPU address.
    input  wire logic [7:0]  cpu_wdata,         // CPU write data.
    input  wire logic        cpu_wr,            // CPU write strobe.
    input  wire logic        cpu_rd,            // CPU read strobe.
    output logic             rom_read_sel,      // Program array read.
    output logic             ee_read_sel,       // Erasable array read.
    output logic      [13:0] rom_cell_addr,     // Array cell address.
    output logic             rom_user_off,      // User array disabled.
    output logic             rom_extra_col,     // Extra columns.
    output logic             rom_extra_row,     // Extra rows.
    output logic      [1:0]  rom_stress,        // Stress test code.
    output logic      [15:0] rom_prog_addr,     // Latched program address.
    output logic      [7:0]  rom_prog_data,     // Latched program data.
    output logic             rom_b5_ignore,     // Bit 5 is don't care.
    output logic             rom_vpp_on,        // Program array voltage.
    output logic      [8:0]  ee_prog_addr,      // Latched erasable offset.
    output logic      [7:0]  ee_prog_data,      // Latched erasable data.
    output logic             ee_cfg_target,     // Target is config byte.
    output logic             ee_erase_mode,     // Erase selected.
    output logic      [1:0]  ee_erase_size,     // Erase extent code.
    output logic             ee_half_odd,       // Odd-row test program.
    output logic             ee_half_even,      // Even-row test program.
    output logic             ee_vpp_on,         // Erasable array voltage.
    output logic             program_array_map_enable,  // Config latch, forced high in single-chip mode.
    output logic             erasable_array_map_enable, // Config latch.
    output logic             cfg_nocop,         // Config latch.
    output logic             cfg_nosec          // Config latch.
);

    localparam int CNT_W = $clog2(PROTECT_WINDOW + 1);

    // Refuse window lengths the counter cannot serve.
    if (PROTECT_WINDOW < 1 || PROTECT_WINDOW > 4096) begin : g_chk
        $error("PROTECT_WINDOW out of range");
    end

    typedef struct packed {
        logic             loaded;
        logic [CNT_W-1:0] win_cnt;
        logic             vpp_s1;
        logic             vpp_s2;
        logic             multi_byte_program_enable;
        logic             onetime_array_latch;
        logic             extra_column_select;
        logic             extra_row_select;
        logic [1:0]       stress;
        logic             onetime_array_voltage_enable;
        logic             ee_odd;
        logic             ee_even;
        logic             ee_byte;
        logic             ee_row;
        logic             ee_erase;
        logic             ee_lat;
        logic             ee_pgm;
        logic [4:0]       block_protect_register;
        logic [3:0]       cfg;
        logic [15:0]      r_addr;
        logic [7:0]       r_data;
        logic [8:0]       e_addr;
        logic [7:0]       e_data;
        logic             e_cfg;
        logic [13:0]      cell_addr;
        logic [7:0]       rdata;
    } npc_state_s;

    npc_state_s s;
    npc_state_s next_s;
    logic       rst_m;
    logic       rst_sync_b;

    // Address within [lo, hi].
    function automatic logic in_win(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction

    // Protect bit guarding an erasable-array offset.
    function automatic logic region_guard(input logic [8:0] off,
                                          input logic [4:0] bp);
        if (off < npc_pkg::BP_R1_START) begin
            region_guard = bp[0];
        end else if (off < npc_pkg::BP_R2_START) begin
            region_guard = bp[1];
        end else if (off < npc_pkg::BP_R3_START) begin
            region_guard = bp[2];
        end else begin
            region_guard = bp[3];
        end
    endfunction

    // Reset release through two flip-flops.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m      <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_m      <= 1'b1;
            rst_sync_b <= rst_m;
        end
    end

    logic       rom_hit;
    logic       ee_hit;
    logic       map_rom;
    logic       single;
    logic       spec;
    logic       ee_guarded;
    logic [8:0] ee_off;

    // Array decode shared by the state update and the select outputs.
    always_comb begin
        single  = (mode_sel == npc_pkg::NPC_MODE_SINGLE);
        spec    = special_mode_flag;
        map_rom = s.cfg[npc_pkg::CF_PROGRAM_ARRAY_MAP_ENABLE] | single;
        rom_hit = map_rom &&
                  (in_win(cpu_addr, npc_pkg::ROM_LO_BASE,
                          npc_pkg::ROM_LO_LAST) ||
                   in_win(cpu_addr, npc_pkg::ROM_HI_BASE,
                          npc_pkg::ROM_HI_LAST));
        ee_hit  = s.cfg[npc_pkg::CF_ERASABLE_ARRAY_MAP_ENABLE] && !s.ee_lat &&
                  in_win(cpu_addr, npc_pkg::EE_BASE,
                         npc_pkg::EE_LAST);
        ee_off  = cpu_addr[8:0] - npc_pkg::EE_BASE[8:0];
        if (s.e_cfg) begin
            ee_guarded = s.block_protect_register[npc_pkg::BP_CFG];
        end else if (s.ee_erase && !s.ee_byte && !s.ee_row) begin
            ee_guarded = |s.block_protect_register[3:0];
        end else begin
            ee_guarded = region_guard(s.e_addr, s.block_protect_register);
        end
    end

    // Next-state logic for every register of the block.
    always_comb begin
        next_s        = s;
        next_s.vpp_s1 = vpp_detect;
        next_s.vpp_s2 = s.vpp_s1;
        next_s.rdata  = 8'h00;
        if (s.win_cnt != CNT_W'(PROTECT_WINDOW)) begin
            next_s.win_cnt = s.win_cnt + CNT_W'(1);
        end
        if (!s.loaded) begin
            next_s.loaded = 1'b1;
            next_s.cfg    = config_cells;
            next_s.cfg[npc_pkg::CF_PROGRAM_ARRAY_MAP_ENABLE] =
                (mode_sel != npc_pkg::NPC_MODE_EXPANDED);
        end

        // Register writes.
        if (reg_wr) begin
            unique case (reg_addr)
                npc_pkg::OFF_ONETIME_CTRL: begin
                    if (spec) begin
                        next_s.multi_byte_program_enable    = reg_wdata[npc_pkg::OT_MBE];
                        next_s.extra_column_select  = reg_wdata[npc_pkg::OT_EXTRA_COLUMN_SELECT];
                        next_s.extra_row_select  = reg_wdata[npc_pkg::OT_EXTRA_ROW_SELECT];
                        next_s.stress = {reg_wdata[npc_pkg::OT_ST_HI],
                                         reg_wdata[npc_pkg::OT_ST_LO]};
                    end
                    if (!s.onetime_array_voltage_enable) begin
                        next_s.onetime_array_latch = reg_wdata[npc_pkg::OT_LAT] &&
                                      (s.onetime_array_latch || s.vpp_s2);
                    end
                    if (s.onetime_array_latch) begin
                        next_s.onetime_array_voltage_enable = reg_wdata[npc_pkg::OT_PGM];
                    end
                end
                npc_pkg::OFF_ERASABLE_CTRL: begin
                    if (spec) begin
                        next_s.ee_odd  = reg_wdata[npc_pkg::EE_ODD];
                        next_s.ee_even = reg_wdata[npc_pkg::EE_EVEN];
                    end
                    next_s.ee_byte  = reg_wdata[npc_pkg::EE_BYTE];
                    next_s.ee_row   = reg_wdata[npc_pkg::EE_ROW];
                    next_s.ee_erase = reg_wdata[npc_pkg::EE_ERASE];
                    next_s.ee_lat   = reg_wdata[npc_pkg::EE_LAT];
                    next_s.ee_pgm   = reg_wdata[npc_pkg::EE_PGM];
                end
                npc_pkg::OFF_BLOCK_PROTECT: begin
                    for (int i = 0; i < npc_pkg::BP_WIDTH; i++) begin
                        if (reg_wdata[i]) begin
                            next_s.block_protect_register[i] = 1'b1;
                        end else if (spec ||
                                     s.win_cnt < CNT_W'(PROTECT_WINDOW)) begin
                            next_s.block_protect_register[i] = 1'b0;
                        end
                    end
                end
                npc_pkg::OFF_CONFIG: begin
                    if (spec) begin
                        next_s.cfg = reg_wdata[3:0];
                    end
                    if (s.ee_lat) begin
                        next_s.e_cfg  = 1'b1;
                        next_s.e_data = reg_wdata;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads answer in the following cycle.
        if (reg_rd) begin
            unique case (reg_addr)
                npc_pkg::OFF_ONETIME_CTRL: begin
                    next_s.rdata = {s.multi_byte_program_enable & spec, 1'b0, s.onetime_array_latch,
                                    s.extra_column_select & spec, s.extra_row_select & spec,
                                    s.stress & {2{spec}}, s.onetime_array_voltage_enable};
                end
                npc_pkg::OFF_ERASABLE_CTRL: begin
                    next_s.rdata = {s.ee_odd, s.ee_even, 1'b0, s.ee_byte,
                                    s.ee_row, s.ee_erase, s.ee_lat,
                                    s.ee_pgm};
                end
                npc_pkg::OFF_BLOCK_PROTECT: begin
                    next_s.rdata = {3'h0, s.block_protect_register};
                end
                npc_pkg::OFF_CONFIG: begin
                    next_s.rdata = {4'h0, s.cfg};
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end

        // Program-array writes latch address and data while latched.
        if (cpu_wr && s.onetime_array_latch && rom_hit) begin
            next_s.r_addr = cpu_addr;
            next_s.r_data = cpu_wdata;
        end

        // Erasable-array writes latch the target while latched.
        if (cpu_wr && s.ee_lat && s.cfg[npc_pkg::CF_ERASABLE_ARRAY_MAP_ENABLE] &&
            in_win(cpu_addr, npc_pkg::EE_BASE, npc_pkg::EE_LAST)) begin
            next_s.e_addr = ee_off;
            next_s.e_data = cpu_wdata;
            next_s.e_cfg  = 1'b0;
        end

        // Cell address seen by the array for each access.
        if ((cpu_rd || cpu_wr) && rom_hit) begin
            if (s.extra_column_select) begin
                next_s.cell_addr = {cpu_addr[13:5], 5'h00};
            end else if (s.extra_row_select) begin
                next_s.cell_addr = {6'h00, cpu_addr[7:0]};
            end else begin
                next_s.cell_addr = cpu_addr[13:0];
            end
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            s          <= '0;
            s.block_protect_register    <= npc_pkg::RST_BLOCK_PROTECT;
            s.cfg      <= 4'hF;
        end else begin
            s <= next_s;
        end
    end

    // Read selects and array strobes.
    assign rom_read_sel  = cpu_rd && rom_hit && !s.onetime_array_latch;
    assign ee_read_sel   = cpu_rd && ee_hit;
    assign rom_user_off  = s.extra_column_select | s.extra_row_select;
    assign rom_extra_col = s.extra_column_select;
    assign rom_extra_row = s.extra_row_select;
    assign rom_stress    = s.stress;
    assign rom_cell_addr = s.cell_addr;
    assign rom_prog_addr = s.r_addr;
    assign rom_prog_data = s.r_data;
    assign rom_b5_ignore = s.multi_byte_program_enable;
    assign rom_vpp_on    = s.onetime_array_voltage_enable && s.onetime_array_latch;
    assign reg_rdata     = s.rdata;

    // Erasable array programming controls.
    assign ee_prog_addr  = s.e_addr;
    assign ee_prog_data  = s.e_data;
    assign ee_cfg_target = s.e_cfg;
    assign ee_erase_mode = s.ee_erase;
    assign ee_erase_size = s.ee_byte ? npc_pkg::ERASE_BYTE :
                           s.ee_row  ? npc_pkg::ERASE_ROW  :
                                       npc_pkg::ERASE_BULK;
    assign ee_half_odd   = s.ee_odd;
    assign ee_half_even  = s.ee_even;
    assign ee_vpp_on     = s.ee_pgm && s.ee_lat && !ee_guarded;

    // Working configuration latches.
    assign program_array_map_enable  = map_rom;
    assign erasable_array_map_enable = s.cfg[npc_pkg::CF_ERASABLE_ARRAY_MAP_ENABLE];
    assign cfg_nocop                 = s.cfg[npc_pkg::CF_NOCOP];
    assign cfg_nosec                 = s.cfg[npc_pkg::CF_NOSEC];

endmodule

`default_nettype wire

// *** npc_ctrl_asserts.sv ***
/*
 * Port-level checker for the program and erasable memory control block.
 * Assumes it is bound to npc_ctrl and that everything runs on clk.
 */
`timescale 1ns/10ps
`default_nettype none

module npc_chk (
    input wire logic        clk,                       // Clock.
    input wire logic        rst_b,                     // Reset, low.
    input wire logic [5:0]  reg_addr,                  // Offset.
    input wire logic [7:0]  reg_wdata,                 // Write data.
    input wire logic        reg_wr,                    // Write strobe.
    input wire logic        reg_rd,                    // Read strobe.
    input wire logic [7:0]  reg_rdata,                 // Read data.
    input wire logic [1:0]  mode_sel,                  // Mode.
    input wire logic        special_mode_flag,         // Special.
    input wire logic [15:0] cpu_addr,                  // CPU address.
    input wire logic        cpu_rd,                    // CPU read.
    input wire logic        rom_read_sel,              // Array read.
    input wire logic        ee_read_sel,               // Erasable read.
    input wire logic        rom_user_off,              // User off.
    input wire logic        rom_extra_col,             // Extra columns.
    input wire logic        rom_extra_row,             // Extra rows.
    input wire logic        rom_vpp_on,                // Array voltage.
    input wire logic        ee_vpp_on,                 // Erasable voltage.
    input wire logic [1:0]  ee_erase_size,             // Erase extent.
    input wire logic        program_array_map_enable,  // Map enable.
    input wire logic        erasable_array_map_enable  // Map enable.
);
    logic rom_hit;
    logic ee_hit;

    // Address decode of the two array windows.
    assign rom_hit = (cpu_addr >= npc_pkg::ROM_LO_BASE &&
                      cpu_addr <= npc_pkg::ROM_LO_LAST) ||
                     cpu_addr >= npc_pkg::ROM_HI_BASE;
    assign ee_hit  = cpu_addr >= npc_pkg::EE_BASE &&
                     cpu_addr <= npc_pkg::EE_LAST;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    rom_window_a: assert property (rom_read_sel |-> cpu_rd && rom_hit &&
        program_array_map_enable) else $error("array read outside map");
    ee_window_a: assert property (ee_read_sel |-> cpu_rd && ee_hit &&
        erasable_array_map_enable) else $error("erasable read outside map");
    single_map_a: assert property (mode_sel == 2'h2 |->
        program_array_map_enable) else $error("single chip lost array");
    latch_noread_a: assert property (rom_vpp_on |-> !rom_read_sel)
        else $error("array read while programming");
    ee_unmap_a: assert property (ee_vpp_on |-> !ee_read_sel)
        else $error("erasable read while programming");
    pgm_cause_a: assert property ($rose(rom_vpp_on) |->
        $past(reg_wr && reg_addr == npc_pkg::OFF_ONETIME_CTRL &&
              reg_wdata[0], 1) ||
        $past(reg_wr && reg_addr == npc_pkg::OFF_ONETIME_CTRL &&
              reg_wdata[0], 2)) else $error("voltage rose without write");
    xcol_user_a: assert property (rom_extra_col |-> rom_user_off)
        else $error("extra columns with user array on");
    xrow_user_a: assert property (rom_extra_row |-> rom_user_off)
        else $error("extra rows with user array on");
    norm_read_a: assert property ($past(reg_rd &&
        !special_mode_flag && reg_addr == npc_pkg::OFF_ONETIME_CTRL) |->
        (reg_rdata & 8'hDE) == 8'h00) else $error("hidden bits read set");
    erase_code_a: assert property (ee_erase_size != 2'h3)
        else $error("bad erase extent code");
endmodule

bind npc_ctrl npc_chk npc_chk_inst (.clk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .mode_sel, .special_mode_flag, .cpu_addr,
    .cpu_rd, .rom_read_sel, .ee_read_sel, .rom_user_off, .rom_extra_col,
    .rom_extra_row, .rom_vpp_on, .ee_vpp_on, .ee_erase_size,
    .program_array_map_enable, .erasable_array_map_enable);

`default_nettype wire

// *** tb_npc_ctrl.sv ***
/*
 * Self-checking bench for npc_ctrl with a shortened protect window.
 * Assumes the design package is compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_npc_ctrl;
    localparam logic [5:0] BP = npc_pkg::OFF_BLOCK_PROTECT;
    localparam logic [5:0] OT = npc_pkg::OFF_ONETIME_CTRL;
    localparam logic [5:0] EE = npc_pkg::OFF_ERASABLE_CTRL;
    localparam logic [5:0] CF = npc_pkg::OFF_CONFIG;
    logic        clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
    logic        cpu_wr = 0, cpu_rd = 0, special_mode_flag = 0;
    logic        vpp_detect = 0;
    logic [5:0]  reg_addr = 6'h00;
    logic [7:0]  reg_wdata = 8'h00, cpu_wdata = 8'h00;
    logic [7:0]  reg_rdata, rom_prog_data, ee_prog_data;
    logic [1:0]  mode_sel = 2'h2, rom_stress, ee_erase_size;
    logic [3:0]  config_cells = 4'hF;
    logic [15:0] cpu_addr = 16'h0000, rom_prog_addr;
    logic [8:0]  ee_prog_addr;
    logic        rom_read_sel, ee_read_sel, rom_user_off, rom_extra_col;
    logic        rom_extra_row, rom_b5_ignore, rom_vpp_on, ee_vpp_on;
    logic        ee_erase_mode, erasable_array_map_enable;
    logic        program_array_map_enable;
    logic [13:0] rom_cell_addr;
    int          fails = 0, num_checks = 0, cyc = 0;
    logic [17:0] tbl [10] = '{18'h23FFC, 18'h24001, 18'h2BFFD, 18'h2C000,
        18'h34001, 18'h3FFFD, 18'h2D7FC, 18'h2D802, 18'h2DFFE, 18'h2E000};

    npc_ctrl #(.PROTECT_WINDOW(16)) npc_ctrl_inst (.clk, .rst_b, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mode_sel,
        .special_mode_flag, .config_cells, .vpp_detect, .cpu_addr,
        .cpu_wdata, .cpu_wr, .cpu_rd, .rom_read_sel, .ee_read_sel,
        .rom_cell_addr, .rom_user_off, .rom_extra_col, .rom_extra_row,
        .rom_stress, .rom_prog_addr, .rom_prog_data, .rom_b5_ignore,
        .rom_vpp_on, .ee_prog_addr, .ee_prog_data, .ee_cfg_target(),
        .ee_erase_mode, .ee_erase_size, .ee_half_odd(), .ee_half_even(),
        .ee_vpp_on, .program_array_map_enable, .erasable_array_map_enable,
        .cfg_nocop(), .cfg_nosec());

    // Clock far above 1 MHz, 200 MHz from the 2.5 ns half period, and a
    // cycle ceiling that cuts a hang short.
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            give_verdict();
        end
    end

    task give_verdict;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask

    // Register bus cycles; each returns just after its effect has landed.
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        #1;
    endtask

    task rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk(16'(reg_rdata), 16'(e));
    endtask

    // CPU array cycles: a write and a read with its select checks.
    task cw(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'h1;
        @(posedge clk);
        cpu_wr <= 1'h0;
        #1;
    endtask

    task cr(input logic [15:0] a, input logic er, input logic ee);
        @(posedge clk);
        cpu_addr <= a;
        cpu_rd <= 1'h1;
        #1 chk(16'(rom_read_sel), 16'(er));
        chk(16'(ee_read_sel), 16'(ee));
        @(posedge clk);
        cpu_rd <= 1'h0;
    endtask

    // Protect bits right after reset, then after the window closes.
    task t_window;
        rd(BP, 8'h1F);
        wr(BP, 8'h00);
        rd(BP, 8'h00);
        repeat (20) @(posedge clk);
        wr(BP, 8'h1F);
        rd(BP, 8'h1F);
        wr(BP, 8'h00);
        rd(BP, 8'h1F);
        rd(OT, 8'h00);
        rd(EE, 8'h00);
    endtask

    // One-time array latch and voltage sequencing in a normal mode.
    task t_onetime;
        wr(OT, 8'h20);
        rd(OT, 8'h00);
        @(posedge clk) vpp_detect <= 1'h1;
        repeat (2) @(posedge clk);
        wr(OT, 8'h21);
        rd(OT, 8'h20);
        cw(16'h9123, 8'h5A);
        chk(rom_prog_addr, 16'h9123);
        chk(16'(rom_prog_data), 16'h005A);
        cr(16'h9123, 1'h0, 1'h0);
        wr(OT, 8'h21);
        rd(OT, 8'h21);
        chk(16'(rom_vpp_on), 16'h0001);
        cr(16'h9123, 1'h0, 1'h0);
        wr(OT, 8'h00);
        rd(OT, 8'h20);
        wr(OT, 8'hBE);
        rd(OT, 8'h20);
        wr(OT, 8'h00);
        foreach (tbl[i]) cr(tbl[i][17:2], tbl[i][0], tbl[i][1]);
    endtask

    // Test access, configuration and protect writes in a special mode.
    task t_special;
        special_mode_flag <= 1'h1;
        for (int k = 0; k < 4; k++) begin
            wr(OT, 8'h90 | 8'(k << 1));
            rd(OT, 8'h90 | 8'(k << 1));
            chk(16'(rom_stress), 16'(k));
            chk(16'({rom_b5_ignore, rom_extra_col, rom_user_off}), 16'h7);
        end
        cr(16'hD3FF, 1'h1, 1'h0);
        #1 chk(16'(rom_cell_addr), 16'h13E0);
        wr(OT, 8'h08);
        chk(16'({rom_extra_row, rom_user_off, rom_extra_col}), 16'h6);
        cr(16'hD3FF, 1'h1, 1'h0);
        #1 chk(16'(rom_cell_addr), 16'h00FF);
        wr(OT, 8'h00);
        wr(CF, 8'h0E);
        chk(16'(erasable_array_map_enable), 16'h0000);
        cr(16'hB600, 1'h0, 1'h0);
        wr(CF, 8'h0F);
        wr(BP, 8'h1D);
        rd(BP, 8'h1D);
    endtask

    // Erasable program attempt; the voltage follows the protect map.
    task ep(input logic [15:0] a, input logic e);
        wr(EE, 8'h02);
        cw(a, 8'h33);
        chk(16'(ee_prog_data), 16'h0033);
        chk(16'(ee_prog_addr), a - npc_pkg::EE_BASE);
        cr(a, 1'h0, 1'h0);
        wr(EE, 8'h03);
        chk(16'(ee_vpp_on), 16'(e));
        cr(a, 1'h0, 1'h0);
        wr(EE, 8'h02);
        wr(EE, 8'h00);
    endtask

    // Erase extents, erase mode and the configuration byte guard.
    task t_erase;
        for (int k = 0; k < 4; k++) begin
            wr(EE, 8'h06 | 8'(k << 3));
            chk(16'(ee_erase_size),
                (k == 0) ? 16'h0 : (k == 1) ? 16'h1 : 16'h2);
            chk(16'(ee_erase_mode), 16'h0001);
        end
        wr(EE, 8'h00);
        chk(16'(ee_erase_mode), 16'h0000);
        wr(EE, 8'h02);
        wr(CF, 8'h0F);
        wr(EE, 8'h03);
        chk(16'(ee_vpp_on), 16'h0000);
        wr(EE, 8'h02);
        wr(EE, 8'h00);
        wr(EE, 8'h06);
        cw(16'hB700, 8'hFF);
        wr(EE, 8'h07);
        chk(16'(ee_vpp_on), 16'h0000);
        wr(EE, 8'h06);
        wr(EE, 8'h0E);
        cw(16'hB630, 8'hFF);
        wr(EE, 8'h0F);
        chk(16'(ee_vpp_on), 16'h0001);
        wr(EE, 8'h0E);
        wr(EE, 8'h00);
    endtask

    // Mid-run reset in expanded mode: array unmapped, window reopens.
    task t_reset;
        @(posedge clk);
        special_mode_flag <= 1'h0;
        mode_sel <= 2'h3;
        rst_b <= 1'h0;
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk);
        #1 chk(16'(program_array_map_enable), 16'h0000);
        cr(16'h9000, 1'h0, 1'h0);
        rd(BP, 8'h1F);
        wr(BP, 8'h00);
        rd(BP, 8'h00);
    endtask

    // Main sequence: reset, then each scenario in turn.
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk);
        t_window();
        t_onetime();
        t_special();
        ep(16'hB61F, 1'h0);
        ep(16'hB620, 1'h1);
        ep(16'hB65F, 1'h1);
        ep(16'hB660, 1'h0);
        t_erase();
        t_reset();
        give_verdict();
    end
endmodule

`default_nettype wire
